// File: hdl/frame_timing_and_subsample_control.sv
// Frame timing generator with sub-sampling, clock dividers and gain codes
`timescale 1ns/1ps
`default_nettype none
`include "frame_timing_regs.svh"

// Summary of operation
// - Horizontal and vertical sub-sampling enable independently
// - Pixel tick equals horizontal tick, halved sub-sampled
// - Line sync width independent of sub-sampling
// - Horizontal sub-sampling alone keeps frame length
// - Horizontal clock divides master clock by 1-31
// - All intervals are whole horizontal ticks, except line sync, one clock short at zero row delay
// - Apply flag loads dividers at frame start, clears
// - Array clock divider never affects exposure
// - Row lasts 780 ticks plus row delay
// - Row delay 0-2047, one tick each
// - Delays and lead rows load at frame start
// - Scan rows equal end minus start plus one
// - Frame rows: factor times scan rows plus delay
// - Frame delay 0-8191, one row each
// - Reset row leads readout by lead rows
// - Video gain code is six bits
// - Red, green, blue gain codes six bits each
// - Routing select sends all pixels through green
module frame_timing_and_subsample_control (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [7:0]                    haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic [31:0]                        hrdata,
  output logic                               horiz_tick,
  output logic                               pixel_tick,
  output logic                               array_tick,
  output logic                               line_sync,
  output logic                               frame_sync,
  output logic                               frame_start,
  output logic [12:0]                        read_row,
  output logic                               reset_strobe,
  output logic [12:0]                        reset_row,
  output frame_timing_pkg::gain_t            gain_out
);

  // ************************************************************
  // Helper functions
  // ************************************************************
  function automatic logic div_hit(input logic [4:0] cnt, input logic [4:0] div);
    div_hit = (div <= 5'h01) || (cnt >= div - 5'h01);
  endfunction

  function automatic logic [9:0] scan_rows(input logic [8:0] s, input logic [8:0] e);
    scan_rows = {1'b0, e} - {1'b0, s} + 10'h001;
  endfunction

  // ************************************************************
  // Register file and AHB-Lite slave
  // ************************************************************
  logic                          gain_route_reg;
  logic                          hsub_reg;
  logic                          vsub_reg;
  logic                          interlace_reg;
  logic                          apply_flag_reg;
  logic [5:0]                    video_gain_reg;
  logic [5:0]                    red_gain_reg;
  logic [5:0]                    green_gain_reg;
  logic [5:0]                    blue_gain_reg;
  frame_timing_pkg::timing_cfg_t prog_reg;
  frame_timing_pkg::timing_cfg_t act_reg;
  logic                          dp_write_reg;
  logic [7:0]                    dp_addr_reg;
  logic                          addr_ok;
  logic                          wr_en;
  logic                          apply_wr;
  logic [31:0]                   rd_next;

  assign addr_ok   = hsel && hready && (htrans == frame_timing_pkg::AHB_NONSEQ_T
                                        || htrans == frame_timing_pkg::AHB_SEQ_T);
  assign wr_en     = dp_write_reg;
  assign apply_wr  = wr_en && dp_addr_reg == `OFS_APPLY && hwdata[`BIT_APPLY];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end
    else
    begin
      dp_write_reg <= addr_ok && hwrite && hsize == 3'h2;
      dp_addr_reg  <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gain_route_reg <= 1'b0;
      hsub_reg       <= 1'b0;
      vsub_reg       <= 1'b0;
      interlace_reg  <= 1'b0;
      video_gain_reg <= 6'h00;
      red_gain_reg   <= 6'h00;
      green_gain_reg <= 6'h00;
      blue_gain_reg  <= 6'h00;
      prog_reg       <= '{hdiv: `RST_HDIV, adiv: `RST_ADIV, row_delay: 11'h000,
                          frame_delay: 13'h0000, lead_rows: 13'h0000,
                          scan_start: `RST_SCAN_START, scan_end: `RST_SCAN_END};
    end
    else if (wr_en)
    begin
      case (dp_addr_reg)
        `OFS_MODE_A:      gain_route_reg <= hwdata[`BIT_GAIN_ROUTE];
        `OFS_MODE_B:
        begin
          hsub_reg      <= hwdata[`BIT_HSUB];
          vsub_reg      <= hwdata[`BIT_VSUB];
          interlace_reg <= hwdata[`BIT_INTERLACE];
        end
        `OFS_CLK_DIV:
        begin
          prog_reg.hdiv <= hwdata[`FLD_HDIV];
          prog_reg.adiv <= hwdata[`FLD_ADIV];
        end
        `OFS_ROW_DELAY:   prog_reg.row_delay   <= hwdata[`FLD_ROW_DELAY];
        `OFS_FRAME_DELAY: prog_reg.frame_delay <= hwdata[`FLD_FRAME_DELAY];
        `OFS_LEAD_ROWS:   prog_reg.lead_rows   <= hwdata[`FLD_LEAD];
        `OFS_SCAN_ROWS:
        begin
          prog_reg.scan_start <= hwdata[`FLD_SCAN_START];
          prog_reg.scan_end   <= hwdata[`FLD_SCAN_END];
        end
        `OFS_VIDEO_GAIN:  video_gain_reg <= hwdata[`FLD_GAIN6];
        `OFS_COLOR_GAIN:
        begin
          red_gain_reg   <= hwdata[`FLD_GAIN_R];
          green_gain_reg <= hwdata[`FLD_GAIN_G];
          blue_gain_reg  <= hwdata[`FLD_GAIN_B];
        end
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Frame boundary and apply flag
  // ************************************************************
  logic        htick;
  logic        row_end;
  logic        frame_end;
  logic [11:0] hcnt_reg;
  logic [12:0] row_idx_reg;
  logic [11:0] row_len;
  logic [12:0] frame_rows;
  logic [9:0]  act_scan;
  logic        half_rows;

  // Set by software wins over the clear at frame start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      apply_flag_reg <= 1'b0;
    else if (apply_wr)
      apply_flag_reg <= 1'b1;
    else if (frame_end)
      apply_flag_reg <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      act_reg <= '{hdiv: `RST_HDIV, adiv: `RST_ADIV, row_delay: 11'h000,
                   frame_delay: 13'h0000, lead_rows: 13'h0000,
                   scan_start: `RST_SCAN_START, scan_end: `RST_SCAN_END};
    else if (frame_end && apply_flag_reg)
      act_reg <= prog_reg;
  end

  // ************************************************************
  // Read data
  // ************************************************************
  always_comb
  begin
    rd_next = 32'h0000_0000;
    case (haddr)
      `OFS_MODE_A:      rd_next[`BIT_GAIN_ROUTE] = gain_route_reg;
      `OFS_MODE_B:
      begin
        rd_next[`BIT_HSUB]      = hsub_reg;
        rd_next[`BIT_VSUB]      = vsub_reg;
        rd_next[`BIT_INTERLACE] = interlace_reg;
      end
      `OFS_CLK_DIV:
      begin
        rd_next[`FLD_HDIV] = prog_reg.hdiv;
        rd_next[`FLD_ADIV] = prog_reg.adiv;
      end
      `OFS_APPLY:       rd_next[`BIT_APPLY]       = apply_flag_reg;
      `OFS_ROW_DELAY:   rd_next[`FLD_ROW_DELAY]   = prog_reg.row_delay;
      `OFS_FRAME_DELAY: rd_next[`FLD_FRAME_DELAY] = prog_reg.frame_delay;
      `OFS_LEAD_ROWS:   rd_next[`FLD_LEAD]        = prog_reg.lead_rows;
      `OFS_SCAN_ROWS:
      begin
        rd_next[`FLD_SCAN_START] = prog_reg.scan_start;
        rd_next[`FLD_SCAN_END]   = prog_reg.scan_end;
      end
      `OFS_VIDEO_GAIN:  rd_next[`FLD_GAIN6] = video_gain_reg;
      `OFS_COLOR_GAIN:
      begin
        rd_next[`FLD_GAIN_R] = red_gain_reg;
        rd_next[`FLD_GAIN_G] = green_gain_reg;
        rd_next[`FLD_GAIN_B] = blue_gain_reg;
      end
      `OFS_STATUS:
      begin
        rd_next[`FLD_STAT_ROW]    = row_idx_reg;
        rd_next[`BIT_STAT_ACTIVE] = frame_sync;
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite)
      hrdata <= rd_next;
  end

  // ************************************************************
  // Clock dividers
  // ************************************************************
  logic [4:0] hdiv_cnt_reg;
  logic [4:0] adiv_cnt_reg;
  logic       pix_phase_reg;

  assign htick = div_hit(hdiv_cnt_reg, act_reg.hdiv);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hdiv_cnt_reg <= 5'h00;
    else if (htick || frame_end)
      hdiv_cnt_reg <= 5'h00;
    else
      hdiv_cnt_reg <= hdiv_cnt_reg + 5'h01;
  end

  // Array clock runs apart from the row counters
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      adiv_cnt_reg <= 5'h00;
      array_tick   <= 1'b0;
    end
    else
    begin
      array_tick   <= div_hit(adiv_cnt_reg, act_reg.adiv);
      adiv_cnt_reg <= div_hit(adiv_cnt_reg, act_reg.adiv) ? 5'h00 : adiv_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      horiz_tick    <= 1'b0;
      pixel_tick    <= 1'b0;
      pix_phase_reg <= 1'b0;
    end
    else
    begin
      horiz_tick <= htick;
      if (htick)
        pix_phase_reg <= (hsub_reg && !row_end) ? ~pix_phase_reg : 1'b1;
      pixel_tick <= htick && (!hsub_reg || pix_phase_reg);
    end
  end

  // ************************************************************
  // Row and frame counters
  // ************************************************************
  assign row_len    = `ROW_OP_CYCLES + {1'b0, act_reg.row_delay};
  assign act_scan   = scan_rows(act_reg.scan_start, act_reg.scan_end);
  assign half_rows  = vsub_reg || interlace_reg;
  assign frame_rows = (half_rows ? {4'h0, act_scan[9:1]} : {3'h0, act_scan})
                      + act_reg.frame_delay;
  assign row_end    = htick && hcnt_reg == row_len - 12'h001;
  assign frame_end  = row_end && row_idx_reg >= frame_rows - 13'h0001;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hcnt_reg <= 12'h000;
    else if (row_end)
      hcnt_reg <= 12'h000;
    else if (htick)
      hcnt_reg <= hcnt_reg + 12'h001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      row_idx_reg <= 13'h0000;
    else if (frame_end)
      row_idx_reg <= 13'h0000;
    else if (row_end)
      row_idx_reg <= row_idx_reg + 13'h0001;
  end

  // ************************************************************
  // Sync, readout row and rolling reset
  // ************************************************************
  logic [12:0] next_row;
  logic [13:0] tgt_sum;

  assign next_row = frame_end ? 13'h0000 : row_idx_reg + 13'h0001;
  assign tgt_sum  = {1'b0, next_row} + {1'b0, act_reg.lead_rows};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      line_sync    <= 1'b0;
      frame_sync   <= 1'b0;
      frame_start  <= 1'b0;
      read_row     <= 13'h0000;
      reset_strobe <= 1'b0;
      reset_row    <= 13'h0000;
    end
    else
    begin
      line_sync    <= hcnt_reg < `ROW_OP_CYCLES && !row_end;
      frame_sync   <= {3'h0, row_idx_reg} < (half_rows ? act_scan >> 1 : act_scan);
      frame_start  <= frame_end;
      reset_strobe <= row_end;
      if (row_end)
      begin
        read_row  <= next_row;
        reset_row <= tgt_sum >= {1'b0, frame_rows} ? 13'(tgt_sum - {1'b0, frame_rows})
                                                   : tgt_sum[12:0];
      end
    end
  end

  // ************************************************************
  // Gain codes
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gain_out <= '0;
    else
    begin
      gain_out.video <= video_gain_reg;
      gain_out.green <= green_gain_reg;
      gain_out.red   <= gain_route_reg ? green_gain_reg : red_gain_reg;
      gain_out.blue  <= gain_route_reg ? green_gain_reg : blue_gain_reg;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_frame_cut;
    frame_end && apply_flag_reg;
  endsequence

  sequence s_loaded;
    act_reg == $past(prog_reg);
  endsequence

  a_hdiv_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    (htick && act_reg.hdiv > 5'h01 && !frame_end) |=> !htick)
    else $error("horizontal tick too close");

  a_pix_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    (htick && !hsub_reg) |=> pixel_tick)
    else $error("pixel tick missing");

  a_pix_half: assert property (@(posedge hclk) disable iff (!hresetn)
    (pixel_tick && hsub_reg && $stable(hsub_reg) && !reset_strobe) |=> !pixel_tick)
    else $error("pixel tick not halved");

  a_line_sync_end: assert property (@(posedge hclk) disable iff (!hresetn)
    (htick && hcnt_reg == `ROW_OP_CYCLES - 12'h001 && !row_end) |=> ##1 !line_sync)
    else $error("line sync wrong length");

  a_row_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    row_end |=> hcnt_reg == 12'h000 && reset_strobe)
    else $error("row did not wrap");

  a_apply_load: assert property (@(posedge hclk) disable iff (!hresetn)
    s_frame_cut |=> s_loaded)
    else $error("settings not loaded at frame start");

  a_apply_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (frame_end && !apply_flag_reg) |=> $stable(act_reg))
    else $error("settings changed without apply");

  a_apply_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_frame_cut and !apply_wr) |=> !apply_flag_reg && frame_start)
    else $error("apply flag not cleared");

  a_frame_rows: assert property (@(posedge hclk) disable iff (!hresetn)
    row_end && !frame_end |=> row_idx_reg == $past(row_idx_reg) + 13'h0001)
    else $error("row index did not advance");

  a_reset_lead: assert property (@(posedge hclk) disable iff (!hresetn)
    reset_strobe && act_reg.lead_rows == 13'h0000 && $stable(act_reg)
    |-> reset_row == read_row)
    else $error("reset row off readout row");

  a_gain_route: assert property (@(posedge hclk) disable iff (!hresetn)
    gain_route_reg [*2] |-> gain_out.red == gain_out.green
                          && gain_out.blue == gain_out.green)
    else $error("gain routing not through green");

endmodule // frame_timing_and_subsample_control
`default_nettype wire

// File: hdl/frame_timing_pkg.sv
// Types shared by the frame timing block
package frame_timing_pkg;
  typedef struct packed {
    logic [4:0]  hdiv;
    logic [4:0]  adiv;
    logic [10:0] row_delay;
    logic [12:0] frame_delay;
    logic [12:0] lead_rows;
    logic [8:0]  scan_start;
    logic [8:0]  scan_end;
  } timing_cfg_t;
  typedef struct packed {
    logic [5:0] video;
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } gain_t;
  typedef enum logic [1:0] {
    AHB_IDLE_T,
    AHB_BUSY_T,
    AHB_NONSEQ_T,
    AHB_SEQ_T
  } htrans_t;
endpackage

// File: hdl/frame_timing_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FRAME_TIMING_REGS_SVH
`define FRAME_TIMING_REGS_SVH
`define OFS_MODE_A        8'h00
`define OFS_MODE_B        8'h04
`define OFS_CLK_DIV       8'h08
`define OFS_APPLY         8'h0c
`define OFS_ROW_DELAY     8'h10
`define OFS_FRAME_DELAY   8'h14
`define OFS_LEAD_ROWS     8'h18
`define OFS_SCAN_ROWS     8'h1c
`define OFS_VIDEO_GAIN    8'h20
`define OFS_COLOR_GAIN    8'h24
`define OFS_STATUS        8'h28
`define BIT_GAIN_ROUTE    0
`define BIT_HSUB          0
`define BIT_VSUB          1
`define BIT_INTERLACE     2
`define BIT_APPLY         0
`define FLD_HDIV          4:0
`define FLD_ADIV          12:8
`define FLD_ROW_DELAY     10:0
`define FLD_FRAME_DELAY   12:0
`define FLD_LEAD          12:0
`define FLD_SCAN_START    8:0
`define FLD_SCAN_END      24:16
`define FLD_GAIN6         5:0
`define FLD_GAIN_R        5:0
`define FLD_GAIN_G        13:8
`define FLD_GAIN_B        21:16
`define FLD_STAT_ROW      12:0
`define BIT_STAT_ACTIVE   16
`define ROW_OP_CYCLES     12'h30c
`define RST_HDIV          5'h01
`define RST_ADIV          5'h02
`define RST_SCAN_START    9'h000
`define RST_SCAN_END      9'h003
`endif

// File: verif/capture_host.sv
// Capture host model that measures line and frame timing of the pixel stream
`timescale 1ns/1ps
`default_nettype none
module capture_host (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pixel_tick,
  input  wire logic line_sync,
  input  wire logic frame_start,
  output var  int   sync_len,
  output var  int   pix_cnt,
  output var  int   frame_len
);
  int   s_run;
  int   p_run;
  int   f_run;
  logic ls_q;
  // ****************************************
  // Line and frame measurement
  // ****************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {s_run, p_run, f_run, sync_len, pix_cnt, frame_len} <= '0;
      ls_q <= 1'b0;
    end
    else
    begin
      ls_q <= line_sync;
      f_run <= frame_start ? 1 : f_run + 1;
      if (frame_start)
        frame_len <= f_run;
      if (line_sync)
      begin
        s_run <= s_run + 1;
        p_run <= p_run + int'(pixel_tick);
      end
      else if (ls_q)
      begin
        sync_len <= s_run;
        pix_cnt <= p_run;
        s_run <= 0;
        p_run <= 0;
      end
    end
  end
endmodule // capture_host
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking testbench of the frame timing block
`timescale 1ns/1ps
`default_nettype none
`include "frame_timing_regs.svh"
module tb_top;
  logic                    hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0]              haddr;
  logic [1:0]              htrans;
  logic [2:0]              hsize;
  logic [31:0]             hwdata, hrdata, rnd, q;
  logic                    pixel_tick, line_sync, frame_start, reset_strobe;
  logic [12:0]             read_row, reset_row;
  frame_timing_pkg::gain_t gain_out;
  int                      sync_len, pix_cnt, frame_len, lead_e, rows_e, cycles;
  int                      fail_count, comparisons;
  bit                      arm;
  assign hready = hreadyout;
  frame_timing_and_subsample_control uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .horiz_tick(), .pixel_tick(pixel_tick), .array_tick(), .line_sync(line_sync),
    .frame_sync(), .frame_start(frame_start), .read_row(read_row),
    .reset_strobe(reset_strobe), .reset_row(reset_row), .gain_out(gain_out));
  capture_host host (.hclk(hclk), .hresetn(hresetn), .pixel_tick(pixel_tick),
    .line_sync(line_sync), .frame_start(frame_start), .sync_len(sync_len),
    .pix_cnt(pix_cnt), .frame_len(frame_len));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [2:0] sz, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= sz;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    r = hrdata;
    chk(hresp === 1'b0, "response not okay");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 3'b010, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, 3'b010, r);
  endtask
  task automatic wait_fs();
    int n;
    n = 0;
    @(negedge hclk);
    while (frame_start !== 1'b1 && n < 20000)
    begin
      @(negedge hclk);
      n++;
    end
    if (n >= 20000)
      chk(1'b0, "no frame start");
    @(posedge hclk);
  endtask
  task automatic gcmp(input logic [23:0] e);
    @(posedge hclk);
    @(negedge hclk);
    chk(gain_out === e, "gain output");
    @(posedge hclk);
  endtask
  // Program a timing set, apply it, then measure one whole frame against the model
  task automatic run_cfg(input int hd, input int rdl, input int fd, input int ld,
                         input int hs, input int vs);
    logic [31:0] r;
    arm = 0;
    wr(`OFS_MODE_B, 32'(hs + 2 * vs));
    wr(`OFS_CLK_DIV, 32'(hd + 256 * (hd + 4)));
    wr(`OFS_ROW_DELAY, 32'(rdl));
    wr(`OFS_FRAME_DELAY, 32'(fd));
    wr(`OFS_LEAD_ROWS, 32'(ld));
    wr(`OFS_APPLY, 32'h1);
    wait_fs();
    rd(`OFS_APPLY, r);
    chk(r[0] === 1'b0, "apply flag not cleared");
    rows_e = (vs != 0 ? 2 : 4) + fd;
    lead_e = ld;
    arm = 1;
    wait_fs();
    @(negedge hclk);
    chk(frame_len == rows_e * (780 + rdl) * hd, "frame length");
    chk(sync_len == 780 * hd - int'(rdl == 0), "line sync width");
    chk(pix_cnt == (hs != 0 ? 390 : 780 - int'(rdl == 0)), "pixel ticks per line");
    @(posedge hclk);
    $display("test timing hdiv=%0d row_delay_count=%0d hsub=%0d vsub=%0d done", hd, rdl, hs, vs);
  endtask
  always @(negedge hclk)
    if (arm && reset_strobe === 1'b1)
      chk(reset_row === 13'((int'(read_row) + lead_e) % rows_e), "reset row");
  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  initial
  begin
    {hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    rnd = 32'hbaadb21d;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`OFS_CLK_DIV, q);
    chk(q === 32'h0000_0201, "clock divider reset");
    rd(`OFS_SCAN_ROWS, q);
    chk(q === 32'h0003_0000, "scan window reset");
    rd(8'h3c, q);
    chk(q === 32'h0, "unmapped read");
    wr(`OFS_SCAN_ROWS, 32'h0003_0000);
    rnd = lfsr(rnd);
    run_cfg(1, int'(rnd[5:0]), 1, 2, 0, 0);
    run_cfg(1, 0, 1, 2, 1, 0);
    run_cfg(1, 5, 1, 1, 0, 1);
    run_cfg(2, 0, 0, 3, 0, 0);
    arm = 0;
    wr(`OFS_MODE_A, 32'h0);
    rnd = lfsr(rnd);
    wr(`OFS_VIDEO_GAIN, rnd);
    gcmp({rnd[5:0], 18'h0});
    rd(`OFS_VIDEO_GAIN, q);
    chk(q === {26'h0, rnd[5:0]}, "video gain field");
    bus(1'b1, `OFS_VIDEO_GAIN, ~rnd, 3'b000, q);
    rd(`OFS_VIDEO_GAIN, q);
    chk(q === {26'h0, rnd[5:0]}, "byte write ignored");
    rnd = lfsr(rnd);
    wr(`OFS_COLOR_GAIN, rnd);
    gcmp({q[5:0], rnd[5:0], rnd[13:8], rnd[21:16]});
    wr(`OFS_MODE_A, 32'h1);
    gcmp({q[5:0], rnd[13:8], rnd[13:8], rnd[13:8]});
    $display("test gains done");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
